// [design/gea_pkg.sv]
/*
  Shared constants for the event-arming and buffered-transfer block:
  condition indices, reset values, widths and transfer states.
  Assumes nothing of its surroundings; imported whole by every module.
*/
`default_nettype none
package gea_pkg;

  // condition indices within the arm set and pending vector
  localparam int EV_N = 9;
  localparam int EV_SRQ = 0;
  localparam int EV_GAIN = 1;
  localparam int EV_CTRL = 2;
  localparam int EV_TRIG = 3;
  localparam int EV_CLR = 4;
  localparam int EV_TALK = 5;
  localparam int EV_LSTN = 6;
  localparam int EV_IDLE = 7;
  localparam int EV_CHG = 8;

  // values after reset
  localparam logic [EV_N-1:0] ARM_RST = 9'h000;
  localparam logic [EV_N-1:0] PEND_RST = 9'h000;
  localparam logic EMUL_RST = 1'b0;
  localparam logic DIR_RST = 1'b0;

  // default data path shape
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 20;

  typedef enum logic [0:0] {
    GEA_XF_IDLE = 1'b0,
    GEA_XF_MOVE = 1'b1
  } gea_xf_e;

endpackage
`default_nettype wire

// [design/gea_addr_if.sv]
/*
  Carrier between the transfer control and the buffer address generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface gea_addr_if #(
  parameter int AW = 20
);
  logic load;
  logic [AW-1:0] start;
  logic dec;
  logic step;
  logic [AW-1:0] addr;

  modport ctl (output load, output start, output dec, output step,
               input addr);
  modport gen (input load, input start, input dec, input step,
               output addr);
endinterface
`default_nettype wire

// [design/gea_fifo.sv]
/*
  Byte FIFO between the bus side and the buffer memory side.
  Assumes one clock, synchronous reset, valid/ready on both sides.
*/
`timescale 1ns/1ns
`default_nettype none
module gea_fifo
  import gea_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [design/gea_addr_gen.sv]
/*
  Buffer memory address generator: loads a start address and steps it
  up or down by one per byte moved.
  Assumes load and step never come in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module gea_addr_gen
  import gea_pkg::*;
#(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control from the transfer logic
  gea_addr_if.gen a
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a.addr <= '0;
    end else if (a.load) begin
      a.addr <= a.start;
    end else if (a.step) begin
      a.addr <= a.dec ? a.addr - 1'b1 : a.addr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [design/gea_event_arm.sv]
/*
  Event arming and buffer direction for a bus interface board: armed
  bus and role conditions latch sticky pending flags that raise one
  host attention status; bytes of a buffered transfer pass a FIFO and
  are written to an address that steps up or down per byte.
  Assumes the bus engine gives role, addressing and command events as
  synchronous levels and pulses, and the host strobes its settings.
*/
// Summary of operation
// - any mix of conditions may be armed, each raising attention alone
// - armed service request condition fires when the request bit sets
// - armed gained-control condition fires on becoming active controller
// - armed became-controller fires on peripheral to controller move
// - armed trigger fires on group trigger received as peripheral
// - armed clear fires on device clear received as peripheral
// - armed talk fires on being addressed as talker, as peripheral
// - armed listen fires on being addressed as listener, as peripheral
// - armed idle fires on being unaddressed as talker and listener, as peripheral
// - armed any-change fires on every address status transition
// - any-change covers gained control, controller, talk, listen, idle
// - role conditions fire only while the address change bit is set
// - attention status is disabled after reset until configured on
// - increment direction adds one to the address per byte moved
// - decrement direction subtracts one from the address per byte
// - as peripheral, drive service request line while request bit set
`timescale 1ns/1ns
`default_nettype none
module gea_event_arm
  import gea_pkg::*;
#(
  parameter int DW = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic cfg_load_i,
  input wire logic cfg_emul_i,
  input wire logic arm_load_i,
  input wire logic [EV_N-1:0] arm_set_i,
  input wire logic dir_load_i,
  input wire logic dir_dec_i,
  // acknowledge of pending flags
  input wire logic [EV_N-1:0] ack_i,
  // role and addressing state from the bus engine
  input wire logic srq_bit_i,
  input wire logic rsv_i,
  input wire logic is_ctrl_i,
  input wire logic talk_i,
  input wire logic listen_i,
  input wire logic addr_chg_i,
  input wire logic trig_cmd_i,
  input wire logic clr_cmd_i,
  // host attention and status
  output logic attn_o,
  output logic [EV_N-1:0] pend_o,
  output logic [EV_N-1:0] arm_o,
  output logic emul_o,
  output logic dir_dec_o,
  // bus service request line, open drain
  output logic srq_o,
  output logic srq_oe_o,
  // transfer control
  input wire logic xfer_start_i,
  input wire logic [AW-1:0] start_addr_i,
  input wire logic xfer_stop_i,
  output logic busy_o,
  // bytes in from the bus side
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  input wire logic [DW-1:0] byte_i,
  // bytes out to buffer memory
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output logic [DW-1:0] mem_data_o,
  output logic [AW-1:0] mem_addr_o
);

  logic [EV_N-1:0] arm_mask;
  logic [EV_N-1:0] pend;
  logic [EV_N-1:0] raw_ev;
  logic [EV_N-1:0] set_ev;
  logic [EV_N-1:0] next_pend;
  logic emul_en;
  logic dir_dec;
  logic srq_prev;
  logic ctrl_prev;
  logic talk_prev;
  logic lstn_prev;
  logic idle_prev;
  logic is_periph;
  logic idle_now;
  logic srq_drive;
  gea_xf_e state;
  gea_xf_e next_state;
  logic fifo_valid;
  logic fifo_ready;
  logic moved;

  gea_addr_if #(.AW(AW)) aif ();

  assign is_periph = !is_ctrl_i;
  assign idle_now = !talk_i && !listen_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      emul_en <= EMUL_RST;
    end else if (cfg_load_i) begin
      emul_en <= cfg_emul_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_mask <= ARM_RST;
    end else if (arm_load_i) begin
      arm_mask <= arm_set_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_dec <= DIR_RST;
    end else if (dir_load_i) begin
      dir_dec <= dir_dec_i;
    end
  end

  // edge history; idle starts at its own level so reset is no idle edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_prev <= 1'b0;
      ctrl_prev <= 1'b0;
      talk_prev <= 1'b0;
      lstn_prev <= 1'b0;
      idle_prev <= 1'b1;
    end else begin
      srq_prev <= srq_bit_i;
      ctrl_prev <= is_ctrl_i;
      talk_prev <= talk_i;
      lstn_prev <= listen_i;
      idle_prev <= idle_now;
    end
  end

  always_comb begin
    raw_ev = '0;
    raw_ev[EV_SRQ] = srq_bit_i && !srq_prev;
    // role edges gated by change bit
    raw_ev[EV_GAIN] = is_ctrl_i && !ctrl_prev && addr_chg_i;
    raw_ev[EV_CTRL] = is_ctrl_i && !ctrl_prev && addr_chg_i;
    raw_ev[EV_TRIG] = trig_cmd_i && is_periph;
    raw_ev[EV_CLR] = clr_cmd_i && is_periph;
    raw_ev[EV_TALK] = talk_i && !talk_prev && is_periph && addr_chg_i;
    raw_ev[EV_LSTN] = listen_i && !lstn_prev && is_periph && addr_chg_i;
    raw_ev[EV_IDLE] = idle_now && !idle_prev && is_periph && addr_chg_i;
    raw_ev[EV_CHG] = addr_chg_i && ((is_ctrl_i != ctrl_prev) ||
                     (talk_i != talk_prev) || (listen_i != lstn_prev));
  end

  assign set_ev = raw_ev & arm_mask & {EV_N{emul_en}};

  assign next_pend = (pend & ~ack_i) | set_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= PEND_RST;
    end else begin
      pend <= next_pend;
    end
  end

  assign attn_o = emul_en && (pend != '0);
  assign pend_o = pend;
  assign arm_o = arm_mask;
  assign emul_o = emul_en;
  assign dir_dec_o = dir_dec;

  // pull line low while requesting as peripheral
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_drive <= 1'b0;
    end else begin
      srq_drive <= rsv_i && is_periph;
    end
  end

  assign srq_o = 1'b0;
  assign srq_oe_o = srq_drive;

  // transfer sequencing
  always_comb begin
    next_state = state;
    case (state)
      GEA_XF_IDLE: begin
        if (xfer_start_i) begin
          next_state = GEA_XF_MOVE;
        end
      end
      GEA_XF_MOVE: begin
        if (xfer_stop_i) begin
          next_state = GEA_XF_IDLE;
        end
      end
      default: begin
        next_state = GEA_XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= GEA_XF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // start address taken as given, no range check
  assign aif.load = (state == GEA_XF_IDLE) && xfer_start_i;
  assign aif.start = start_addr_i;
  assign aif.dec = dir_dec;
  assign aif.step = moved;

  // bytes queue while idle, so the bus side may run ahead of the memory
  assign mem_valid_o = (state == GEA_XF_MOVE) && fifo_valid;
  assign fifo_ready = (state == GEA_XF_MOVE) && mem_ready_i;
  assign moved = mem_valid_o && mem_ready_i;
  assign mem_addr_o = aif.addr;
  assign busy_o = (state == GEA_XF_MOVE);

  gea_fifo #(
    .W(DW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(byte_valid_i),
    .in_ready_o(byte_ready_o),
    .in_data_i(byte_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(mem_data_o)
  );

  gea_addr_gen #(
    .AW(AW)
  ) u_addr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a(aif.gen)
  );

  sequence srq_rise_s;
    !srq_bit_i ##1 srq_bit_i && arm_mask[EV_SRQ] && emul_en;
  endsequence

  sequence talk_addr_s;
    !talk_i ##1 talk_i && addr_chg_i && !is_ctrl_i;
  endsequence

  sequence ctrl_take_s;
    !is_ctrl_i ##1 is_ctrl_i && addr_chg_i;
  endsequence

  srq_raise_a: assert property (@(posedge clk_i)
    disable iff (rst_i) srq_rise_s |=> pend[EV_SRQ] && attn_o)
    else $error("service request edge did not raise attention");

  ctrl_raise_a: assert property (@(posedge clk_i)
    disable iff (rst_i) ctrl_take_s ##0 (arm_mask[EV_CTRL] &&
    arm_mask[EV_GAIN] && emul_en) |=> pend[EV_CTRL] && pend[EV_GAIN])
    else $error("controller edge not latched");

  talk_raise_a: assert property (@(posedge clk_i)
    disable iff (rst_i) talk_addr_s ##0 (arm_mask[EV_TALK] && emul_en)
    |=> pend[EV_TALK])
    else $error("talk edge not latched");

  // talk only with the change bit
  talk_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i) !pend[EV_TALK] ##1 pend[EV_TALK] |->
    $past(addr_chg_i))
    else $error("talk flag set without address change");

  cmd_raise_a: assert property (@(posedge clk_i)
    disable iff (rst_i) (trig_cmd_i && clr_cmd_i && !is_ctrl_i &&
    emul_en && arm_mask[EV_TRIG] && arm_mask[EV_CLR])
    |=> pend[EV_TRIG] && pend[EV_CLR] && attn_o)
    else $error("trigger or clear command not latched");

  chg_raise_a: assert property (@(posedge clk_i)
    disable iff (rst_i) ctrl_take_s ##0 (arm_mask[EV_CHG] && emul_en)
    |=> pend[EV_CHG])
    else $error("address change not latched");

  emul_gate_a: assert property (@(posedge clk_i)
    disable iff (rst_i) !emul_en |-> !attn_o)
    else $error("attention raised while emulation off");

  disarm_a: assert property (@(posedge clk_i)
    disable iff (rst_i) !arm_mask[EV_IDLE] && !pend[EV_IDLE] |=>
    !pend[EV_IDLE])
    else $error("disarmed idle flag set");

  sticky_a: assert property (@(posedge clk_i)
    disable iff (rst_i) pend[EV_LSTN] && !ack_i[EV_LSTN] |=>
    pend[EV_LSTN])
    else $error("pending flag dropped without acknowledge");

  // service request line follows request bit
  srq_line_a: assert property (@(posedge clk_i)
    disable iff (rst_i) rsv_i && !is_ctrl_i |=> srq_oe_o && !srq_o)
    else $error("service request line not driven");

  addr_inc_a: assert property (@(posedge clk_i)
    disable iff (rst_i) moved && !dir_dec |=>
    mem_addr_o == AW'($past(mem_addr_o) + 1'b1))
    else $error("address did not increment");

  addr_dec_a: assert property (@(posedge clk_i)
    disable iff (rst_i) moved && dir_dec |=>
    mem_addr_o == AW'($past(mem_addr_o) - 1'b1))
    else $error("address did not decrement");

  addr_load_a: assert property (@(posedge clk_i)
    disable iff (rst_i) state == GEA_XF_IDLE && xfer_start_i |=>
    mem_addr_o == $past(start_addr_i) && busy_o)
    else $error("start address not loaded");

endmodule
`default_nettype wire

// [sim/gea_mem_model.sv]
/*
  Buffer memory model on the drain side: accepts bytes with a ready
  that wanders, and stops accepting while the bench asks for a stall.
  Assumes the bench clock and the design's valid/data/address outputs.
*/
`timescale 1ns/1ns
`default_nettype none
module gea_mem_model
  import gea_pkg::*;
(
  // clock
  input wire logic clk_i,
  // bench control
  input wire logic stall_i,
  // write port from the design
  input wire logic mem_valid_i,
  input wire logic [BYTE_W-1:0] mem_data_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic mem_ready_o
);
  logic [3:0] pat = 4'h9;
  logic rdy = 1'b0;
  logic [BYTE_W-1:0] mem [logic [ADDR_W-1:0]];
  assign mem_ready_o = rdy;
  // uneven ready so back-to-back and gapped writes both occur
  always @(posedge clk_i) begin
    if (mem_valid_i && rdy) mem[mem_addr_i] = mem_data_i;
    pat <= {pat[2:0], pat[3] ^ pat[2]};
    rdy <= #1 !stall_i && pat[0];
  end
endmodule
`default_nettype wire

// [sim/tb_gea_event_arm.sv]
/*
  Self-checking bench for the event arming block: conditions, attention,
  service request line and buffered transfers in both directions.
  Assumes the memory model of gea_mem_model on the drain side.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_gea_event_arm;
  import gea_pkg::*;
  logic clk_i, rst_i, cfg_load_i, cfg_emul_i, arm_load_i, dir_load_i;
  logic dir_dec_i, srq_bit_i, rsv_i, is_ctrl_i, talk_i, listen_i;
  logic addr_chg_i, trig_cmd_i, clr_cmd_i, xfer_start_i, xfer_stop_i;
  logic byte_valid_i, byte_ready_o, mem_valid_o, mem_ready_i, stall, em;
  logic attn_o, emul_o, dir_dec_o, srq_o, srq_oe_o, busy_o;
  logic [EV_N-1:0] arm_set_i, ack_i, pend_o, arm_o;
  logic [ADDR_W-1:0] start_addr_i, mem_addr_o;
  logic [BYTE_W-1:0] byte_i, mem_data_o;
  logic [ADDR_W+BYTE_W-1:0] exp_q[$];
  logic [31:0] rs;
  int err_count, num_checks;

  gea_event_arm i_gea_event_arm (.clk_i, .rst_i, .cfg_load_i, .cfg_emul_i,
    .arm_load_i, .arm_set_i, .dir_load_i, .dir_dec_i, .ack_i, .srq_bit_i,
    .rsv_i, .is_ctrl_i, .talk_i, .listen_i, .addr_chg_i, .trig_cmd_i,
    .clr_cmd_i, .attn_o, .pend_o, .arm_o, .emul_o, .dir_dec_o, .srq_o,
    .srq_oe_o, .xfer_start_i, .start_addr_i, .xfer_stop_i, .busy_o,
    .byte_valid_i, .byte_ready_o, .byte_i, .mem_valid_o, .mem_ready_i,
    .mem_data_o, .mem_addr_o);
  gea_mem_model i_gea_mem_model (.clk_i, .stall_i(stall),
    .mem_valid_i(mem_valid_o), .mem_data_i(mem_data_o),
    .mem_addr_i(mem_addr_o), .mem_ready_o(mem_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic cyc;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // pre/post: {service bit, controller, talker, listener}; cmd: {trig, clr}
  task automatic ev(input logic [3:0] pre, input logic [3:0] post,
                    input logic [1:0] cmd, input logic chg,
                    input logic [8:0] armv, input logic [8:0] exp);
    arm_load_i = 1'b1;
    arm_set_i = '0;
    ack_i = '1;
    {srq_bit_i, is_ctrl_i, talk_i, listen_i} = pre;
    cyc;
    arm_set_i = armv;
    cyc;
    arm_load_i = 1'b0;
    ack_i = '0;
    {srq_bit_i, is_ctrl_i, talk_i, listen_i} = post;
    {trig_cmd_i, clr_cmd_i} = cmd;
    addr_chg_i = chg;
    cyc;
    {trig_cmd_i, clr_cmd_i} = 2'h0;
    addr_chg_i = 1'b0;
    chk(arm_o, armv, "arm set");
    chk(pend_o, exp, "pending after event");
    chk(attn_o, em && exp != 0, "attention");
    cyc;
    chk(pend_o, exp, "pending held");
    ack_i = '1;
    cyc;
    chk({attn_o, pend_o}, 0, "pending acknowledged");
  endtask

  task automatic xfer(input logic dec, input logic [ADDR_W-1:0] s);
    logic [ADDR_W-1:0] a;
    int k;
    dir_load_i = 1'b1;
    dir_dec_i = dec;
    cyc;
    dir_load_i = 1'b0;
    chk(dir_dec_o, dec, "direction");
    stall = 1'b1;
    xfer_start_i = 1'b1;
    start_addr_i = s;
    cyc;
    xfer_start_i = 1'b0;
    chk({busy_o, mem_addr_o}, {1'b1, s}, "start address");
    a = s;
    for (int i = 0; i < 20; i++) begin
      if (i == FIFO_DEPTH) begin
        chk(byte_ready_o, 0, "fifo full refuses");
        stall = 1'b0;
      end
      rs = xs(rs);
      byte_valid_i = 1'b1;
      byte_i = rs[7:0];
      k = 0;
      while (!byte_ready_o && k < 50) begin
        cyc;
        k++;
      end
      chk(byte_ready_o, 1, "fifo accepts");
      exp_q.push_back({a, byte_i});
      a = dec ? a - 1'b1 : a + 1'b1;
      cyc;
    end
    byte_valid_i = 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 300) begin
      cyc;
      k++;
    end
    chk(exp_q.size(), 0, "all bytes written");
    xfer_stop_i = 1'b1;
    cyc;
    xfer_stop_i = 1'b0;
    chk(busy_o, 0, "transfer stopped");
  endtask

  // every accepted memory write takes the oldest note off the queue
  always @(posedge clk_i) begin
    if (!rst_i && mem_valid_o && mem_ready_i) begin
      num_checks++;
      if (exp_q.size() == 0 ||
          {mem_addr_o, mem_data_o} !== exp_q[0]) begin
        err_count++;
        $display("[ERR] %0t memory write %0h", $time, mem_addr_o);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end

  initial begin
    rst_i = 1'b1;
    {cfg_load_i, cfg_emul_i, arm_load_i, dir_load_i, dir_dec_i} = '0;
    {srq_bit_i, rsv_i, is_ctrl_i, talk_i, listen_i, addr_chg_i} = '0;
    {trig_cmd_i, clr_cmd_i, xfer_start_i, xfer_stop_i, byte_valid_i} = '0;
    arm_set_i = '0;
    ack_i = '0;
    start_addr_i = '0;
    byte_i = '0;
    stall = 1'b1;
    em = 1'b0;
    rs = 32'he992;
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk({attn_o, pend_o, arm_o, emul_o, dir_dec_o, srq_oe_o, busy_o,
         mem_valid_o}, 0, "reset state");
    chk(mem_addr_o, 0, "reset address");
    ev(4'h0, 4'h2, 2'h0, 1'b1, 9'h1ff, 9'h000);
    cfg_load_i = 1'b1;
    cfg_emul_i = 1'b1;
    cyc;
    cfg_load_i = 1'b0;
    em = 1'b1;
    chk(emul_o, 1, "emulation on");
    ev(4'h0, 4'h8, 2'h0, 1'b0, 9'h001, 9'h001);
    ev(4'h0, 4'h4, 2'h0, 1'b1, 9'h002, 9'h002);
    ev(4'h0, 4'h4, 2'h0, 1'b1, 9'h004, 9'h004);
    ev(4'h0, 4'h0, 2'h2, 1'b0, 9'h008, 9'h008);
    ev(4'h4, 4'h4, 2'h2, 1'b0, 9'h008, 9'h000);
    ev(4'h0, 4'h0, 2'h1, 1'b0, 9'h010, 9'h010);
    ev(4'h4, 4'h4, 2'h1, 1'b0, 9'h010, 9'h000);
    ev(4'h0, 4'h0, 2'h3, 1'b0, 9'h018, 9'h018);
    ev(4'h0, 4'h2, 2'h0, 1'b1, 9'h020, 9'h020);
    ev(4'h0, 4'h2, 2'h0, 1'b0, 9'h020, 9'h000);
    ev(4'h0, 4'h1, 2'h0, 1'b1, 9'h040, 9'h040);
    ev(4'h0, 4'h1, 2'h0, 1'b1, 9'h020, 9'h000);
    ev(4'h2, 4'h0, 2'h0, 1'b1, 9'h080, 9'h080);
    ev(4'h2, 4'h1, 2'h0, 1'b1, 9'h100, 9'h100);
    ev(4'h0, 4'h2, 2'h0, 1'b1, 9'h1ff, 9'h120);
    ev(4'h0, 4'h4, 2'h0, 1'b1, 9'h1ff, 9'h106);
    ev(4'h1, 4'h0, 2'h0, 1'b1, 9'h100, 9'h100);
    rs = xs(rs);
    ev(4'h0, 4'h8, 2'h0, 1'b0, rs[8:0] | 9'h001, 9'h001);
    rsv_i = 1'b1;
    is_ctrl_i = 1'b0;
    cyc;
    chk({srq_oe_o, srq_o}, 2'h2, "service line driven low");
    is_ctrl_i = 1'b1;
    cyc;
    chk(srq_oe_o, 0, "service line off as controller");
    is_ctrl_i = 1'b0;
    rsv_i = 1'b0;
    cyc;
    chk(srq_oe_o, 0, "service line released");
    // lowest address when stepping up, highest when stepping down
    xfer(1'b0, 20'h0_0100);
    xfer(1'b1, 20'h0_02ff);
    conclude;
  end
endmodule
`default_nettype wire
